// File: src/pae_evaluator.sv
// Purpose: Four process alarms with APB configuration and status
// Assumes: Source values synchronous to pclk, sampled every cycle
// Notes:   APB slave answers with zero wait states
//
// Overview of operation
// [R1] Absolute form compares monitored value to levels
// [R2] Beyond a level gives alarm, boolean true
// [R3] Double types trip boolean on outer level
// [R4] Deviation form uses monitored minus reference
// [R5] Deadband hysteresis on every exit threshold
// [R6] High alarm above level one, exit minus band
// [R7] Low alarm below level two, exit plus band
// [R8] Double high warning on lower level
// [R9] Double high alarm on higher level
// [R10] Warning lights indicator, boolean stays false
// [R11] Double low warning below higher level
// [R12] Double low alarm below lower level
// [R13] Latching keeps pending until acknowledged
// [R14] Self clearing drops pending when condition ends
// [R15] Exit cancels pending only when self clearing
// [R16] Logic only: no indicator, no acknowledge
// [R17] Indicator flashes while acknowledge pending
// [R18] Indicator steady after acknowledge while active
// [R19] Boolean true in alarm; self clearing until acked
// [R20] Level one higher, level two lower
// [R21] Four independent alarm instances
// [R22] External ack input plus panel key
// [R23] Evaluate every cycle, clear on reset
// [R24] Registered flash from divided clock
`timescale 1ns/10ps
module pae_evaluator #(
    parameter int FLASH_CYC = pae_pkg::PAE_FLASH_CYC
) (
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [11:0]                         paddr,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    input  wire logic [pae_pkg::PAE_SRC_W-1:0]       source_values,
    input  wire logic [pae_pkg::PAE_NUM_ALARMS-1:0]  panel_ack_key,
    input  wire logic [7:0]                          ext_logic_in,
    output logic      [pae_pkg::PAE_NUM_ALARMS-1:0]  alarm_bool,
    output logic      [pae_pkg::PAE_NUM_ALARMS-1:0]  indicator
);
    import pae_pkg::*;

    localparam int N = PAE_NUM_ALARMS;

    logic [31:0]          cfg_r   [N];
    logic [PAE_VAL_W-1:0] lvl1_r  [N];
    logic [PAE_VAL_W-1:0] lvl2_r  [N];
    logic [PAE_VAL_W-1:0] dband_r [N];
    logic [31:0]          extsel_r;
    logic [N-1:0]         sw_ack;
    logic [N-1:0]         warn_w;
    logic [N-1:0]         alarm_w;
    logic [N-1:0]         pend_w;
    logic [N-1:0]         bool_w;
    logic [N-1:0]         ind_w;
    logic [31:0]          flash_cnt_r;
    logic                 flash_r;
    logic                 wr_en;
    logic                 rd_en;
    logic                 addr_ok;
    logic [31:0]          rd_nxt;
    logic [1:0]           blk;
    logic [11:0]          sub;

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign blk     = paddr[5:4];
    assign sub     = {8'h00, paddr[3:0]};
    assign addr_ok = (paddr[1:0] == 2'b00) &&
                     (paddr < PAE_OFF_STATUS ||
                      paddr == PAE_OFF_STATUS || paddr == PAE_OFF_ACK ||
                      paddr == PAE_OFF_EXTSEL);

    // Configuration writes; alarm block registers per instance [R21]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < N; i++) begin
                cfg_r[i]   <= PAE_CFG_RST;
                lvl1_r[i]  <= PAE_LVL_RST;
                lvl2_r[i]  <= PAE_LVL_RST;
                dband_r[i] <= PAE_LVL_RST;
            end
            extsel_r <= PAE_EXTSEL_RST;
        end else if (wr_en && addr_ok) begin
            if (paddr < PAE_OFF_STATUS) begin
                case (sub)
                    PAE_OFF_CFG:   cfg_r[blk]   <= pwdata;
                    PAE_OFF_LVL1:  lvl1_r[blk]  <= pwdata[PAE_VAL_W-1:0];
                    PAE_OFF_LVL2:  lvl2_r[blk]  <= pwdata[PAE_VAL_W-1:0];
                    PAE_OFF_DBAND: dband_r[blk] <= pwdata[PAE_VAL_W-1:0];
                    default: ;
                endcase
            end else if (paddr == PAE_OFF_EXTSEL) begin
                extsel_r <= pwdata;
            end
        end
    end

    // Software ack is a one-cycle pulse on write of ones
    assign sw_ack = (wr_en && paddr == PAE_OFF_ACK) ? pwdata[N-1:0]
                                                    : {N{1'b0}};

    // Status and readback mux
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (paddr < PAE_OFF_STATUS) begin
            case (sub)
                PAE_OFF_CFG:   rd_nxt = cfg_r[blk];
                PAE_OFF_LVL1:  rd_nxt = {16'h0000, lvl1_r[blk]};
                PAE_OFF_LVL2:  rd_nxt = {16'h0000, lvl2_r[blk]};
                PAE_OFF_DBAND: rd_nxt = {16'h0000, dband_r[blk]};
                default:       rd_nxt = 32'h0000_0000;
            endcase
        end else if (paddr == PAE_OFF_STATUS) begin
            rd_nxt = {12'h000, bool_w, ind_w, pend_w, warn_w, alarm_w};
        end else if (paddr == PAE_OFF_EXTSEL) begin
            rd_nxt = extsel_r;
        end
    end

    // Zero wait APB answer; unmapped or misaligned gives slave error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (psel && !penable && !pwrite && addr_ok) begin
                prdata <= rd_nxt;
            end
        end
    end

    // Free-running flash divider, registered square wave [R24]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cnt_r <= 32'h0000_0000;
            flash_r     <= 1'b0;
        end else if (flash_cnt_r >= 32'(FLASH_CYC - 1)) begin
            flash_cnt_r <= 32'h0000_0000;
            flash_r     <= ~flash_r;
        end else begin
            flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
        end
    end

    // One evaluator per alarm instance
    for (genvar g = 0; g < N; g++) begin : g_alarm
        pae_alarm_if                  ai ();
        logic signed [PAE_VAL_W-1:0] mon;
        logic signed [PAE_VAL_W-1:0] refv;
        logic [PAE_SEL_W-1:0]        msel;
        logic [PAE_SEL_W-1:0]        rsel;
        logic [2:0]                  esel;
        logic                        ext_on;

        assign msel = cfg_r[g][PAE_CFG_MON +: PAE_SEL_W];
        assign rsel = cfg_r[g][PAE_CFG_REF +: PAE_SEL_W];
        assign mon  = source_values[msel*PAE_VAL_W +: PAE_VAL_W];
        assign refv = source_values[rsel*PAE_VAL_W +: PAE_VAL_W];

        // Absolute form against zero, deviation as difference [R1] [R4]
        assign ai.value = (cfg_r[g][PAE_CFG_FORM +: 2] == PAE_DEVIATION_FORM)
                          ? PAE_VAL_W'(mon - refv) : mon;
        assign ai.level1         = lvl1_r[g];
        assign ai.level2         = lvl2_r[g];
        assign ai.deadband_value = dband_r[g];
        assign ai.alarm_type     = cfg_r[g][PAE_CFG_TYPE +: 2];
        assign ai.action         = cfg_r[g][PAE_CFG_ACT +: 2];

        // External source is per alarm: enable bit plus input select
        assign esel   = extsel_r[g*4 +: 3];
        assign ext_on = extsel_r[g*4 + 3] & ext_logic_in[esel];
        // Panel key stays effective with external source set [R22]
        assign ai.ack = panel_ack_key[g] | sw_ack[g] | ext_on;

        pae_alarm_unit u_unit (
            .pclk    (pclk),
            .presetn (presetn),
            .ai      (ai.eval)
        );

        assign warn_w[g]  = ai.warn;
        assign alarm_w[g] = ai.alarm;
        assign pend_w[g]  = ai.pending;
        assign bool_w[g]  = ai.bool_out;
        assign ind_w[g]   = ai.indicator_on;
    end

    // Registered outputs; boolean is alarm condition masked by self clearing ack [R2] [R19]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_bool <= {N{1'b0}};
            indicator  <= {N{1'b0}};
        end else begin
            alarm_bool <= bool_w;
            // Flash while pending, steady otherwise [R17] [R18]
            for (int i = 0; i < N; i++) begin
                indicator[i] <= pend_w[i] ? (ind_w[i] & flash_r) : ind_w[i];
            end
        end
    end
endmodule // pae_evaluator

// File: common/pae_pkg.sv
// Purpose: Shared constants and types for the process alarm evaluator
// Assumes: Signed two's complement process values, 32-bit APB data
// Notes:   Offsets are byte addresses, one aligned word per register
package pae_pkg;
    localparam int          PAE_NUM_ALARMS = 4;
    localparam int          PAE_VAL_W      = 16;
    localparam int          PAE_SEL_W      = 3;
    localparam int          PAE_NUM_SRC    = 8;
    localparam int          PAE_SRC_W      = PAE_NUM_SRC * PAE_VAL_W;

    // Per alarm block of four words, base 0x10 * alarm index
    localparam logic [11:0] PAE_OFF_CFG    = 12'h000;
    localparam logic [11:0] PAE_OFF_LVL1   = 12'h004;
    localparam logic [11:0] PAE_OFF_LVL2   = 12'h008;
    localparam logic [11:0] PAE_OFF_DBAND  = 12'h00C;
    localparam logic [11:0] PAE_OFF_STATUS = 12'h040;
    localparam logic [11:0] PAE_OFF_ACK    = 12'h044;
    localparam logic [11:0] PAE_OFF_EXTSEL = 12'h048;

    // Configuration word field positions
    localparam int          PAE_CFG_FORM   = 0;
    localparam int          PAE_CFG_TYPE   = 2;
    localparam int          PAE_CFG_ACT    = 4;
    localparam int          PAE_CFG_MON    = 8;
    localparam int          PAE_CFG_REF    = 12;
    localparam logic [31:0] PAE_CFG_RST    = 32'h0000_0000;
    localparam logic [15:0] PAE_LVL_RST    = 16'h0000;
    localparam logic [31:0] PAE_EXTSEL_RST = 32'h0000_0000;

    // Flash half period: 250 ms at 250 MHz
    localparam int          PAE_CLK_MHZ    = 250;
    localparam int          PAE_FLASH_MS   = 250;
    localparam int          PAE_FLASH_CYC  = PAE_FLASH_MS * 1000 * PAE_CLK_MHZ;

    typedef enum logic [1:0] {
        PAE_ABSOLUTE_FORM, PAE_DEVIATION_FORM
    } pae_form_t;
    typedef enum logic [1:0] {
        PAE_HIGH_LOW_TYPE, PAE_DOUBLE_HIGH_TYPE, PAE_DOUBLE_LOW_TYPE
    } pae_type_t;
    typedef enum logic [1:0] {
        PAE_LATCHING_ACTION, PAE_SELF_CLEARING_ACTION, PAE_LOGIC_ONLY_ACTION
    } pae_action_t;
endpackage

// File: common/pae_alarm_if.sv
// Purpose: Carries one alarm's settings and results between modules
// Assumes: Single pclk domain
// Notes:   Levels and deadband are signed process values
`timescale 1ns/10ps
interface pae_alarm_if;
    import pae_pkg::*;
    logic signed [PAE_VAL_W-1:0] value;
    logic signed [PAE_VAL_W-1:0] level1;
    logic signed [PAE_VAL_W-1:0] level2;
    logic signed [PAE_VAL_W-1:0] deadband_value;
    logic [1:0]                  alarm_type;
    logic [1:0]                  action;
    logic                        ack;
    logic                        warn;
    logic                        alarm;
    logic                        pending;
    logic                        bool_out;
    logic                        indicator_on;
    modport ctrl (output value, level1, level2, deadband_value, alarm_type,
                  action, ack, input warn, alarm, pending, bool_out,
                  indicator_on);
    modport eval (input value, level1, level2, deadband_value, alarm_type,
                  action, ack, output warn, alarm, pending, bool_out,
                  indicator_on);
endinterface

// File: src/pae_alarm_unit.sv
// Purpose: One alarm: thresholds with deadband, action and acknowledge
// Assumes: Value already formed (absolute or deviation) by the caller
// Notes:   Outputs are combinational from state flops; top registers them
`timescale 1ns/10ps
module pae_alarm_unit (
    input wire logic  pclk,
    input wire logic  presetn,
    pae_alarm_if.eval ai
);
    import pae_pkg::*;

    logic                      hi_r;
    logic                      lo_r;
    logic                      pend_r;
    logic                      hi_nxt;
    logic                      lo_nxt;
    logic signed [PAE_VAL_W:0] v;
    logic signed [PAE_VAL_W:0] l1;
    logic signed [PAE_VAL_W:0] l2;
    logic signed [PAE_VAL_W:0] db;
    logic                      cond;
    logic                      rise;
    logic                      acked_r;

    // Widen by one bit so level plus deadband cannot wrap
    assign v  = {ai.value[PAE_VAL_W-1], ai.value};
    assign l1 = {ai.level1[PAE_VAL_W-1], ai.level1};
    assign l2 = {ai.level2[PAE_VAL_W-1], ai.level2};
    assign db = {ai.deadband_value[PAE_VAL_W-1], ai.deadband_value};

    // Threshold with hysteresis; hi_r tracks level one, lo_r level two
    always_comb begin
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        case (ai.alarm_type)
            PAE_HIGH_LOW_TYPE, PAE_DOUBLE_HIGH_TYPE: begin
                // Level one above, exit below level minus band [R6] [R9]
                if (v > l1) hi_nxt = 1'b1;
                else if (v < l1 - db) hi_nxt = 1'b0;
                if (ai.alarm_type == PAE_HIGH_LOW_TYPE) begin
                    // Low alarm on level two [R7]
                    if (v < l2) lo_nxt = 1'b1;
                    else if (v > l2 + db) lo_nxt = 1'b0;
                end else begin
                    // Warning on lower level, upward [R8]
                    if (v > l2) lo_nxt = 1'b1;
                    else if (v < l2 - db) lo_nxt = 1'b0;
                end
            end
            PAE_DOUBLE_LOW_TYPE: begin
                // Warning below level one, alarm below two [R11] [R12]
                if (v < l1) hi_nxt = 1'b1;
                else if (v > l1 + db) hi_nxt = 1'b0;
                if (v < l2) lo_nxt = 1'b1;
                else if (v > l2 + db) lo_nxt = 1'b0;
            end
            default: begin
                hi_nxt = 1'b0;
                lo_nxt = 1'b0;
            end
        endcase
    end

    // Evaluated every cycle, cleared on reset [R23] [R5]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_r <= 1'b0;
            lo_r <= 1'b0;
        end else begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
        end
    end

    // Level one trips double high, level two trips double low [R3] [R20]
    always_comb begin
        case (ai.alarm_type)
            PAE_HIGH_LOW_TYPE: begin
                ai.alarm = hi_r | lo_r;
                ai.warn  = 1'b0;
            end
            PAE_DOUBLE_HIGH_TYPE: begin
                ai.alarm = hi_r;
                ai.warn  = lo_r & ~hi_r;
            end
            PAE_DOUBLE_LOW_TYPE: begin
                ai.alarm = lo_r;
                ai.warn  = hi_r & ~lo_r;
            end
            default: begin
                ai.alarm = 1'b0;
                ai.warn  = 1'b0;
            end
        endcase
    end

    assign cond = ai.alarm | ai.warn;
    // New occurrence only from no condition; escalation does not re-pend
    assign rise = (hi_nxt | lo_nxt) & ~(hi_r | lo_r);

    // Pending ack; a new occurrence beats a same-cycle ack [R13] [R14]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= 1'b0;
        end else if (ai.action == PAE_LOGIC_ONLY_ACTION) begin
            pend_r <= 1'b0; // Never acknowledgeable [R16]
        end else if (rise) begin
            pend_r <= 1'b1;
        end else if (ai.ack) begin
            pend_r <= 1'b0;
        end else if (!cond && ai.action == PAE_SELF_CLEARING_ACTION) begin
            pend_r <= 1'b0; // Leaving state cancels only here [R15]
        end
    end

    // Alarm state acknowledged; gates self clearing boolean
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acked_r <= 1'b0;
        end else if (!ai.alarm) begin
            acked_r <= 1'b0;
        end else if (ai.ack && ai.action == PAE_SELF_CLEARING_ACTION) begin
            acked_r <= 1'b1;
        end
    end

    assign ai.pending = pend_r;
    // Warning never drives the boolean [R10] [R19]
    assign ai.bool_out = ai.alarm &
                         ~(ai.action == PAE_SELF_CLEARING_ACTION && acked_r);
    // Indicator lit in warning or alarm, never for logic only [R16] [R18]
    assign ai.indicator_on = (cond | pend_r) &
                             (ai.action != PAE_LOGIC_ONLY_ACTION);
endmodule // pae_alarm_unit

// File: tb/pae_checker_properties.sv
// Purpose: Port-level properties of the alarm evaluator
// Assumes: Zero wait APB slave, register map of the hand-over
// Notes:   Bound into every evaluator instance
`timescale 1ns/10ps
module pae_checker_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  alarm_bool,
    input wire logic [3:0]  indicator
);
    logic acc;
    logic bad;
    // Access phase and unmapped or misaligned decode
    assign acc = psel && penable;
    assign bad = (paddr[1:0] != 2'h0) || (paddr > 12'h048);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_RESET_QUIET: assert property ($rose(presetn) |->
        alarm_bool == 4'h0 && indicator == 4'h0)
        else $error("outputs active right after reset");
    AST_READY_ACCESS: assert property (acc |-> pready)
        else $error("no ready in access phase");
    AST_READY_ONLY: assert property (!acc |-> !pready)
        else $error("ready outside access phase");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    AST_ERR_BAD: assert property (acc && bad |-> pslverr)
        else $error("unmapped access not refused");
    AST_ERR_GOOD: assert property (acc && !bad |-> !pslverr)
        else $error("mapped access refused");
    AST_ACK_ZERO: assert property (acc && !pwrite &&
        paddr == 12'h044 |-> prdata == 32'h0)
        else $error("acknowledge register not read as zero");
    AST_LVL_UPPER: assert property (acc && !pwrite && !bad &&
        paddr < 12'h040 && paddr[3:2] != 2'h0 |-> prdata[31:16] == 16'h0)
        else $error("level or band upper half not zero");
endmodule // pae_checker_properties

bind pae_evaluator pae_checker_properties pae_checker_properties_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alarm_bool(alarm_bool), .indicator(indicator));

// File: tb/pae_panel_model.sv
// Purpose: Faceplate model: acknowledge keys, logic inputs, lamp watch
// Assumes: Keys are level inputs sampled every cycle
// Notes:   Counts lamp changes so the bench can judge flashing
`timescale 1ns/10ps
module pae_panel_model (
    input wire logic       pclk,
    input wire logic [3:0] indicator,
    output logic     [3:0] panel_ack_key,
    output logic     [7:0] ext_logic_in
);
    int         toggles [4] = '{default: 0};
    logic [3:0] ind_r = 4'h0;
    initial begin
        panel_ack_key = 4'h0;
        ext_logic_in  = 8'h00;
    end
    // One-cycle press; extra edges let pending and lamp settle
    task automatic press(input logic ext, input int k);
        @(posedge pclk);
        if (ext) ext_logic_in[k] <= 1'b1;
        else panel_ack_key[k] <= 1'b1;
        @(posedge pclk);
        ext_logic_in  <= 8'h00;
        panel_ack_key <= 4'h0;
        repeat (2) @(posedge pclk);
    endtask
    // Lamp change counter, a steady lamp never counts
    always @(posedge pclk) begin
        for (int i = 0; i < 4; i++) begin
            if (indicator[i] !== ind_r[i]) toggles[i]++;
        end
        ind_r <= indicator;
    end
endmodule // pae_panel_model

// File: tb/pae_evaluator_test.sv
// Purpose: Self-checking bench for the process alarm evaluator
// Assumes: Zero wait APB, two-cycle source to output latency
// Notes:   Flash half period shortened to four cycles
`timescale 1ns/10ps
module pae_evaluator_test;
    import pae_pkg::*;
    logic                 pclk    = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel    = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite  = 1'b0;
    logic [11:0]          paddr   = 12'h000;
    logic [31:0]          pwdata  = 32'h0;
    logic [PAE_SRC_W-1:0] src     = '0;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [3:0]           keys;
    logic [7:0]           ext;
    logic [3:0]           abool;
    logic [3:0]           ind;
    logic [31:0]          rd;
    logic                 err;
    int                   miscompares  = 0;
    int                   total_checks = 0;
    int                   c0;

    always #2 pclk = ~pclk;

    pae_evaluator #(.FLASH_CYC(4)) pae_evaluator_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .source_values(src),
        .panel_ack_key(keys), .ext_logic_in(ext), .alarm_bool(abool),
        .indicator(ind));
    pae_panel_model pae_panel_model_i (
        .pclk(pclk), .indicator(ind), .panel_ack_key(keys),
        .ext_logic_in(ext));

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask
    // One APB transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Levels first, config last; alarm 1 still latches a stray low alarm until its config word is written
    task automatic setup(input int i, input logic [31:0] c,
                         input logic [15:0] l1, l2, db);
        logic [11:0] b;
        b = 12'(16 * i);
        apb(1'b1, b + PAE_OFF_LVL1, {16'h0, l1});
        apb(1'b1, b + PAE_OFF_LVL2, {16'h0, l2});
        apb(1'b1, b + PAE_OFF_DBAND, {16'h0, db});
        apb(1'b1, b + PAE_OFF_CFG, c);
    endtask
    // Wait covers the fixed two-edge output latency
    task automatic put(input int k, input logic [15:0] v);
        src[16*k +: 16] <= v;
        repeat (3) @(posedge pclk);
    endtask
    // Expected bits: boolean, pending, warning, alarm
    task automatic stat(input int i, input logic [3:0] e,
                        input logic [3:0] m);
        apb(1'b0, PAE_OFF_STATUS, 32'h0);
        chk({28'h0, rd[16+i], rd[8+i], rd[4+i], rd[i]} & m, {28'h0, e & m});
    endtask
    task automatic lamp(input int i, input logic v);
        repeat (8) begin
            @(posedge pclk);
            chk({31'h0, ind[i]}, {31'h0, v});
        end
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(PAE_OFF_CFG, PAE_CFG_RST);
        rdc(PAE_OFF_LVL1, {16'h0, PAE_LVL_RST});
        rdc(PAE_OFF_EXTSEL, PAE_EXTSEL_RST);
        rdc(12'h04C, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 12'h002, 32'h1);
        chk({31'h0, err}, 32'h1);
        rdc(PAE_OFF_ACK, 32'h0);
        // Sources all zero here; only alarm 1 trips, a low alarm before its config word
        setup(0, 32'h0000_0000, 16'h0064, 16'hFFEC, 16'h0005);
        setup(1, 32'h0000_0114, 16'h0064, 16'h0032, 16'h0005);
        setup(2, 32'h0000_3209, 16'h0000, 16'hFFCE, 16'h0005);
        setup(3, 32'h0000_0420, 16'h0064, 16'hFFF6, 16'h0005);
        rdc(PAE_OFF_DBAND, 32'h5);
        // Alarm 0: absolute, high/low, latching
        put(0, 16'h0032);
        stat(0, 4'h0, 4'hF);
        put(0, 16'h0065);
        stat(0, 4'hD, 4'hF);
        chk({31'h0, abool[0]}, 32'h1);
        put(0, 16'h0061);
        stat(0, 4'hD, 4'hF);
        put(0, 16'h005E);
        stat(0, 4'h4, 4'hF);
        c0 = pae_panel_model_i.toggles[0];
        repeat (16) @(posedge pclk);
        chk(32'(pae_panel_model_i.toggles[0] - c0 >= 3), 32'h1);
        apb(1'b1, PAE_OFF_ACK, 32'h1);
        stat(0, 4'h0, 4'hF);
        put(0, 16'hFFEB);
        stat(0, 4'hD, 4'hF);
        put(0, 16'hFFF0);
        stat(0, 4'hD, 4'hF);
        put(0, 16'hFFF2);
        stat(0, 4'h4, 4'hF);
        // Alarm 1: double high, self clearing
        put(1, 16'h003C);
        stat(1, 4'h6, 4'hF);
        chk({31'h0, abool[1]}, 32'h0);
        put(1, 16'h0028);
        stat(1, 4'h0, 4'hF);
        put(1, 16'h003C);
        put(1, 16'h0065);
        stat(1, 4'hD, 4'hD);
        pae_panel_model_i.press(1'b0, 1);
        stat(1, 4'h1, 4'hD);
        lamp(1, 1'b1);
        put(1, 16'h002C);
        stat(1, 4'h0, 4'hF);
        // Alarm 2: deviation, double low, latching
        put(2, 16'h0064);
        put(3, 16'h006E);
        stat(2, 4'h6, 4'hF);
        put(2, 16'h0032);
        stat(2, 4'hD, 4'hD);
        apb(1'b1, PAE_OFF_EXTSEL, 32'h0000_0D00);
        pae_panel_model_i.press(1'b1, 5);
        stat(2, 4'h9, 4'hD);
        put(2, 16'h0078);
        stat(2, 4'h0, 4'hF);
        put(2, 16'h0032);
        stat(2, 4'hD, 4'hD);
        pae_panel_model_i.press(1'b0, 2);
        stat(2, 4'h9, 4'hD);
        // Alarm 3: logic only, no lamp and no acknowledge
        put(4, 16'h00C8);
        stat(3, 4'h9, 4'hD);
        lamp(3, 1'b0);
        pae_panel_model_i.press(1'b0, 3);
        stat(3, 4'h9, 4'hD);
        chk({28'h0, abool}, 32'hC);
        summarize();
    end
endmodule // pae_evaluator_test
